// ### pcg_pkg.sv
`default_nettype none
package pcg_pkg;
   // register byte offsets inside the system control window
   localparam logic [11:0] PCG_RUN0_OFS = 12'h100;
   localparam logic [11:0] PCG_RUN1_OFS = 12'h104;
   localparam logic [11:0] PCG_SLP0_OFS = 12'h110;
   localparam logic [11:0] PCG_SLP1_OFS = 12'h114;
   localparam logic [11:0] PCG_DEEP0_OFS = 12'h120;
   localparam logic [11:0] PCG_DEEP1_OFS = 12'h124;
   localparam logic [11:0] PCG_CFG_OFS = 12'h130;
   localparam logic [11:0] PCG_STAT_OFS = 12'h140;
   localparam logic [11:0] PCG_MASK_OFS = 12'h144;

   // writable bits; everything else is reserved and reads as zero
   localparam logic [31:0] PCG_SET0_WMASK = 32'h01110348;
   localparam logic [31:0] PCG_DEEP0_WMASK = 32'h01110048;
   localparam logic [31:0] PCG_SET1_WMASK = 32'h010f1313;
   localparam logic [31:0] PCG_CFG_WMASK = 32'h00000001;
   localparam logic [31:0] PCG_IRQ_WMASK = 32'h00000003;

   // reset values
   localparam logic [31:0] PCG_SET0_RST = 32'h00000040;
   localparam logic [31:0] PCG_SET1_RST = 32'h00000000;
   localparam logic [31:0] PCG_CFG_RST = 32'h00000000;
   localparam logic [31:0] PCG_IRQ_RST = 32'h00000000;

   // set-0 unit positions
   localparam int PCG_CAN_BIT = 24;
   localparam int PCG_PWM_BIT = 20;
   localparam int PCG_ADC_BIT = 16;
   localparam int PCG_SPD_LSB = 8;
   localparam int PCG_BATT_BIT = 6;
   localparam int PCG_WDOG_BIT = 3;
   // set-1 unit positions
   localparam int PCG_CMP_ZERO_BIT = 24;
   localparam int PCG_TMR3_BIT = 19;
   localparam int PCG_TMR2_BIT = 18;
   localparam int PCG_TMR1_BIT = 17;
   localparam int PCG_TMR0_BIT = 16;
   localparam int PCG_TWI_BIT = 12;
   localparam int PCG_SER1_BIT = 1;
   localparam int PCG_SER0_BIT = 0;
   // own control and status positions
   localparam int PCG_AUTO_GATE_BIT = 0;
   localparam int PCG_ST_FAULT_BIT = 0;
   localparam int PCG_ST_MODE_BIT = 1;

   // converter sample speed codes
   localparam logic [1:0] PCG_SPD_500K = 2'h2;
   localparam logic [1:0] PCG_SPD_250K = 2'h1;
   localparam logic [1:0] PCG_SPD_125K = 2'h0;

   typedef enum logic [1:0] {PCG_MODE_RUN, PCG_MODE_SLEEP, PCG_MODE_DEEP} pcg_mode_type;

   // pick one gating bit out of a register image
   function automatic logic pcg_bit_of(input logic [31:0] v, input logic [4:0] idx);
      pcg_bit_of = v[idx];
   endfunction
endpackage
`default_nettype wire

// ### pcg_gate_sel.sv
`timescale 1ns/100ps
`default_nettype none
module pcg_gate_sel
   import pcg_pkg::*;
(
   input wire pcg_pkg::pcg_mode_type mode,
   input wire logic auto_sel,
   input wire logic [31:0] run_val,
   input wire logic [31:0] sleep_val,
   input wire logic [31:0] deep_val,
   output logic [31:0] eff_val
);
   // without automatic gating the run copy rules every mode
   always_comb
   begin
      eff_val = run_val;
      if (auto_sel)
      begin
         unique case (mode)
            PCG_MODE_RUN: eff_val = run_val;
            PCG_MODE_SLEEP: eff_val = sleep_val;
            PCG_MODE_DEEP: eff_val = deep_val;
            default: eff_val = run_val;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### pcg_ctrl.sv
// Functional notes
// - gating bit 1 clocks its unit; 0 leaves it unclocked and disabled
// - access to an unclocked unit gets a bus fault, not completion
// - gating bits reset to 0 unless documented otherwise
// - battery-domain bit 6 of set-0 resets to 1, register reset 0x40
// - separate run, sleep and deep-sleep copies of each gating register
// - sleep and deep copies apply only with automatic gating set
// - set-0: bus controller bit 24, motor PWM bit 20, converter bit 16
// - set-0 bit 3 gates the watchdog; access while unclocked faults
// - set-0 bits 9:8 pick converter rate: 2=500K, 1=250K, 0=125K
// - reserved bits read-only zero; software preserves them
// - set-1 bit 24 gates comparator 0; unclocked access faults
// - set-1 bit 19 gates timer 3; run set-1 resets to zero
// - set-1 bits 18,17,16 gate timers 2,1,0, reset 0
// - set-1 bit 12 two-wire unit, bits 1 and 0 serial ports
`timescale 1ns/100ps
`default_nettype none
module pcg_ctrl
   import pcg_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire pcg_pkg::pcg_mode_type pwr_mode,
   input wire logic unit_req,
   input wire logic unit_req_set,
   input wire logic [4:0] unit_req_bit,
   output logic unit_fault,
   output logic unit_ok,
   output logic [31:0] unit_clk_en0,
   output logic [31:0] unit_clk_en1,
   output logic [1:0] conv_speed,
   output logic irq
);
   import pcg_pkg::*;

   logic [31:0] run0_r, run1_r, slp0_r, slp1_r, deep0_r, deep1_r;
   logic [31:0] cfg_r, stat_r, mask_r;
   logic [31:0] eff0, eff1, rd_mux;
   logic wr_pend_r, rd_pend_r, hready_r, fault_r, ok_r, irq_r;
   logic [11:0] wr_ofs_r, rd_ofs_r;
   logic [31:0] hrdata_r, en0_r, en1_r;
   logic [1:0] spd_r;
   pcg_mode_type mode_q_r;
   logic addr_ok, rd_take, wr_take, stat_clr, ev_fault, ev_mode, req_gated;

   // transfers of any size are decoded; hsize is accepted as word
   assign addr_ok = hsel && hready && htrans[1];
   assign rd_take = addr_ok && !hwrite;
   assign wr_take = addr_ok && hwrite;

   // write address phase captured, data lands one cycle later
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wr_ofs_r <= 12'h000;
      end
      else
      begin
         wr_pend_r <= wr_take;
         if (wr_take)
            wr_ofs_r <= haddr[11:0];
      end
   end

   // reads insert one wait state so a preceding write is already visible
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend_r <= 1'b0;
         rd_ofs_r <= 12'h000;
         hready_r <= 1'b1;
      end
      else
      begin
         rd_pend_r <= rd_take;
         hready_r <= !rd_take;
         if (rd_take)
            rd_ofs_r <= haddr[11:0];
      end
   end

   // read mux; unmapped offsets answer zero
   always_comb
   begin
      unique case (rd_ofs_r)
         PCG_RUN0_OFS: rd_mux = run0_r;
         PCG_RUN1_OFS: rd_mux = run1_r;
         PCG_SLP0_OFS: rd_mux = slp0_r;
         PCG_SLP1_OFS: rd_mux = slp1_r;
         PCG_DEEP0_OFS: rd_mux = deep0_r;
         PCG_DEEP1_OFS: rd_mux = deep1_r;
         PCG_CFG_OFS: rd_mux = cfg_r;
         PCG_STAT_OFS: rd_mux = stat_r;
         PCG_MASK_OFS: rd_mux = mask_r;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_r <= 32'h00000000;
      else if (rd_pend_r)
         hrdata_r <= rd_mux;
   end

   // gating copies, reserved bits held at zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run0_r <= PCG_SET0_RST;
         slp0_r <= PCG_SET0_RST;
         deep0_r <= PCG_SET0_RST;
         run1_r <= PCG_SET1_RST;
         slp1_r <= PCG_SET1_RST;
         deep1_r <= PCG_SET1_RST;
      end
      else if (wr_pend_r)
      begin
         unique case (wr_ofs_r)
            PCG_RUN0_OFS: run0_r <= hwdata & PCG_SET0_WMASK;
            PCG_SLP0_OFS: slp0_r <= hwdata & PCG_SET0_WMASK;
            PCG_DEEP0_OFS: deep0_r <= hwdata & PCG_DEEP0_WMASK;
            PCG_RUN1_OFS: run1_r <= hwdata & PCG_SET1_WMASK;
            PCG_SLP1_OFS: slp1_r <= hwdata & PCG_SET1_WMASK;
            PCG_DEEP1_OFS: deep1_r <= hwdata & PCG_SET1_WMASK;
            default:
            begin
            end
         endcase
      end
   end

   // configuration (automatic gating select) and interrupt mask
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_r <= PCG_CFG_RST;
         mask_r <= PCG_IRQ_RST;
      end
      else if (wr_pend_r)
      begin
         if (wr_ofs_r == PCG_CFG_OFS)
            cfg_r <= hwdata & PCG_CFG_WMASK;
         if (wr_ofs_r == PCG_MASK_OFS)
            mask_r <= hwdata & PCG_IRQ_WMASK;
      end
   end

   // effective copy chosen from power mode and auto select
   pcg_gate_sel u_sel0 (
      .mode(pwr_mode),
      .auto_sel(cfg_r[PCG_AUTO_GATE_BIT]),
      .run_val(run0_r),
      .sleep_val(slp0_r),
      .deep_val(deep0_r),
      .eff_val(eff0)
   );

   pcg_gate_sel u_sel1 (
      .mode(pwr_mode),
      .auto_sel(cfg_r[PCG_AUTO_GATE_BIT]),
      .run_val(run1_r),
      .sleep_val(slp1_r),
      .deep_val(deep1_r),
      .eff_val(eff1)
   );

   // unit clock enables; speed field masked out
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         en0_r <= PCG_SET0_RST;
         en1_r <= PCG_SET1_RST;
         spd_r <= PCG_SPD_125K;
      end
      else
      begin
         en0_r <= eff0 & ~(32'h00000003 << PCG_SPD_LSB);
         en1_r <= eff1;
         // rate field; deep copy has none so it falls to lowest rate
         spd_r <= eff0[PCG_SPD_LSB +: 2];
      end
   end

   assign req_gated = unit_req_set ? !pcg_bit_of(eff1, unit_req_bit)
                                   : !pcg_bit_of(eff0, unit_req_bit);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fault_r <= 1'b0;
         ok_r <= 1'b0;
      end
      else
      begin
         fault_r <= unit_req && req_gated;
         ok_r <= unit_req && !req_gated;
      end
   end

   // sticky events; set wins over the clear done by a status read
   assign ev_fault = unit_req && req_gated;
   assign ev_mode = pwr_mode != mode_q_r;
   assign stat_clr = rd_pend_r && (rd_ofs_r == PCG_STAT_OFS);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stat_r <= PCG_IRQ_RST;
         mode_q_r <= PCG_MODE_RUN;
      end
      else
      begin
         mode_q_r <= pwr_mode;
         if (stat_clr)
            stat_r <= 32'h00000000;
         if (ev_fault)
            stat_r[PCG_ST_FAULT_BIT] <= 1'b1;
         if (ev_mode)
            stat_r[PCG_ST_MODE_BIT] <= 1'b1;
      end
   end

   // level interrupt, one cycle behind the status bits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_r <= 1'b0;
      else
         irq_r <= |(stat_r & mask_r);
   end

   assign hreadyout = hready_r;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign unit_fault = fault_r;
   assign unit_ok = ok_r;
   assign unit_clk_en0 = en0_r;
   assign unit_clk_en1 = en1_r;
   assign conv_speed = spd_r;
   assign irq = irq_r;

   // read handshake steps
   sequence rd_addr_s;
      rd_take;
   endsequence

   sequence rd_done_s;
      !hreadyout ##1 hreadyout;
   endsequence

   read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_addr_s |=> rd_done_s)
      else $error("read did not finish after one wait state");

   run_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pwr_mode == PCG_MODE_RUN |=> unit_clk_en1 == $past(run1_r))
      else $error("run mode enables do not follow run copy");

   no_auto_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_r[PCG_AUTO_GATE_BIT] && pwr_mode == PCG_MODE_DEEP |=> unit_clk_en1 == $past(run1_r))
      else $error("deep mode without auto gating left run copy");

   sleep_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_r[PCG_AUTO_GATE_BIT] && pwr_mode == PCG_MODE_SLEEP |=> unit_clk_en1 == $past(slp1_r))
      else $error("sleep copy not applied under auto gating");

   deep_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_r[PCG_AUTO_GATE_BIT] && pwr_mode == PCG_MODE_DEEP
      |=> unit_clk_en0[PCG_WDOG_BIT] == $past(deep0_r[PCG_WDOG_BIT]))
      else $error("deep copy not applied under auto gating");

   gated_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
      // status bit rises with the fault pulse; a later status read may clear it legally
      unit_req && req_gated |=> unit_fault && !unit_ok && stat_r[PCG_ST_FAULT_BIT])
      else $error("access to unclocked unit did not fault");

   wdog_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
      unit_req && !unit_req_set && unit_req_bit == 5'h03 && !eff0[PCG_WDOG_BIT] |=> unit_fault)
      else $error("watchdog access while unclocked did not fault");

   rsvd_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (run0_r & ~PCG_SET0_WMASK) == 32'h0 && (deep0_r & ~PCG_DEEP0_WMASK) == 32'h0
      && (run1_r & ~PCG_SET1_WMASK) == 32'h0)
      else $error("reserved gating bit became nonzero");

   speed_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pwr_mode == PCG_MODE_RUN |=> conv_speed == $past(run0_r[PCG_SPD_LSB +: 2]))
      else $error("converter speed does not follow run field");

   irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
      |(stat_r & mask_r) |=> irq)
      else $error("unmasked status did not raise interrupt");
endmodule
`default_nettype wire

// ### pcg_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pcg_ctrl_tb_top;
   import pcg_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   pcg_mode_type pwr_mode = PCG_MODE_RUN;
   logic unit_req = 1'b0;
   logic unit_req_set = 1'b0;
   logic [4:0] unit_req_bit = 5'h0;
   logic unit_fault, unit_ok, irq;
   logic [31:0] unit_clk_en0, unit_clk_en1;
   logic [1:0] conv_speed;
   int bad_count = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   int b0[5] = '{24, 20, 16, 6, 3};
   int b1[8] = '{24, 19, 18, 17, 16, 12, 1, 0};

   pcg_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwr_mode(pwr_mode),
      .unit_req(unit_req), .unit_req_set(unit_req_set), .unit_req_bit(unit_req_bit),
      .unit_fault(unit_fault), .unit_ok(unit_ok), .unit_clk_en0(unit_clk_en0),
      .unit_clk_en1(unit_clk_en1), .conv_speed(conv_speed), .irq(irq));

   // free-running bus clock, 4 ns period
   always #2 hclk = ~hclk;

   task automatic complete_run();
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // register and port words
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // single-bit outputs
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   // bounded wait for the slave; a stuck bus counts as a mismatch
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         bad_count++;
         $display("Error at %0t: bus never ready", $time);
      end
   endtask

   task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0, a};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic ahb_wr(input logic [11:0] a, input logic [31:0] d);
      ahb_xfer(1'b1, a, d);
   endtask

   task automatic ahb_rd_chk(input logic [11:0] a, input logic [31:0] exp);
      ahb_xfer(1'b0, a, 32'h0);
      chk_word(rd, exp);
      chk_bit(hresp, 1'b0);
   endtask

   // enables follow the register one cycle after the write lands
   task automatic settle_en(input logic [31:0] e0, input logic [31:0] e1);
      repeat (2) @(posedge hclk);
      chk_word(unit_clk_en0, e0);
      chk_word(unit_clk_en1, e1);
   endtask

   task automatic unit_chk(input logic s, input int b, input logic ok);
      @(posedge hclk);
      unit_req <= 1'b1;
      unit_req_set <= s;
      unit_req_bit <= b[4:0];
      @(posedge hclk);
      unit_req <= 1'b0;
      @(posedge hclk);
      chk_bit(unit_ok, ok);
      chk_bit(unit_fault, ~ok);
   endtask

   task automatic set_mode(input pcg_mode_type m);
      @(posedge hclk);
      pwr_mode <= m;
      repeat (2) @(posedge hclk);
   endtask

   // watchdog sized well above the few hundred cycles the tests need
   initial
   begin
      #80000;
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end

   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      ahb_rd_chk(PCG_RUN0_OFS, 32'h00000040);
      ahb_rd_chk(PCG_SLP0_OFS, 32'h00000040);
      ahb_rd_chk(PCG_DEEP0_OFS, 32'h00000040);
      ahb_rd_chk(PCG_RUN1_OFS, 32'h00000000);
      ahb_rd_chk(PCG_SLP1_OFS, 32'h00000000);
      ahb_rd_chk(PCG_DEEP1_OFS, 32'h00000000);
      settle_en(32'h00000040, 32'h0);
      unit_chk(1'b0, PCG_WDOG_BIT, 1'b0);
      $display("reset test done");

      // reserved bits stay zero, unmapped place reads zero
      ahb_wr(PCG_RUN0_OFS, 32'hfffffdff);
      ahb_rd_chk(PCG_RUN0_OFS, 32'h01110148);
      ahb_wr(PCG_DEEP0_OFS, 32'hffffffff);
      ahb_rd_chk(PCG_DEEP0_OFS, 32'h01110048);
      ahb_wr(PCG_RUN1_OFS, 32'hffffffff);
      ahb_rd_chk(PCG_RUN1_OFS, 32'h010f1313);
      ahb_wr(12'h1f0, 32'hffffffff);
      ahb_rd_chk(12'h1f0, 32'h0);
      settle_en(32'h01110048, 32'h010f1313);
      $display("reserved test done");

      // every named unit clocked, then every one gated off
      foreach (b0[i]) unit_chk(1'b0, b0[i], 1'b1);
      foreach (b1[i]) unit_chk(1'b1, b1[i], 1'b1);
      unit_chk(1'b0, 5, 1'b0);
      ahb_wr(PCG_RUN0_OFS, 32'h0);
      ahb_wr(PCG_RUN1_OFS, 32'h0);
      settle_en(32'h0, 32'h0);
      foreach (b0[i]) unit_chk(1'b0, b0[i], 1'b0);
      foreach (b1[i]) unit_chk(1'b1, b1[i], 1'b0);
      $display("unit test done");

      // all three legal converter rates
      for (int s = 0; s < 3; s++)
      begin
         ahb_wr(PCG_RUN0_OFS, 32'h00000040 | (s << 8));
         repeat (2) @(posedge hclk);
         chk_word({30'h0, conv_speed}, s);
      end
      $display("speed test done");

      // interrupt: raise, clear by status read, then masked
      // first read returns the fault latched by the earlier gated accesses and clears it
      ahb_rd_chk(PCG_STAT_OFS, 32'h1);
      ahb_wr(PCG_MASK_OFS, 32'h1);
      unit_chk(1'b0, PCG_CAN_BIT, 1'b0);
      repeat (2) @(posedge hclk);
      chk_bit(irq, 1'b1);
      ahb_rd_chk(PCG_STAT_OFS, 32'h1);
      repeat (2) @(posedge hclk);
      chk_bit(irq, 1'b0);
      ahb_wr(PCG_MASK_OFS, 32'h2);
      unit_chk(1'b0, PCG_CAN_BIT, 1'b0);
      repeat (2) @(posedge hclk);
      chk_bit(irq, 1'b0);
      set_mode(PCG_MODE_SLEEP);
      @(posedge hclk);
      chk_bit(irq, 1'b1);
      ahb_rd_chk(PCG_STAT_OFS, 32'h3);
      set_mode(PCG_MODE_RUN);
      ahb_wr(PCG_MASK_OFS, 32'h0);
      repeat (2) @(posedge hclk);
      chk_bit(irq, 1'b0);
      $display("interrupt test done");

      // per-mode copies with and without automatic gating
      ahb_wr(PCG_RUN0_OFS, 32'h00100140);
      ahb_wr(PCG_RUN1_OFS, 32'h00000001);
      ahb_wr(PCG_SLP0_OFS, 32'h01000240);
      ahb_wr(PCG_SLP1_OFS, 32'h00080000);
      ahb_wr(PCG_DEEP0_OFS, 32'h00000008);
      ahb_wr(PCG_DEEP1_OFS, 32'h01000000);
      set_mode(PCG_MODE_SLEEP);
      settle_en(32'h00100040, 32'h1);
      set_mode(PCG_MODE_DEEP);
      settle_en(32'h00100040, 32'h1);
      chk_word({30'h0, conv_speed}, 32'h1);
      ahb_wr(PCG_CFG_OFS, 32'h1);
      settle_en(32'h00000008, 32'h01000000);
      chk_word({30'h0, conv_speed}, 32'h0);
      unit_chk(1'b0, PCG_WDOG_BIT, 1'b1);
      unit_chk(1'b0, PCG_PWM_BIT, 1'b0);
      set_mode(PCG_MODE_SLEEP);
      settle_en(32'h01000040, 32'h00080000);
      chk_word({30'h0, conv_speed}, 32'h2);
      unit_chk(1'b1, PCG_TMR3_BIT, 1'b1);
      set_mode(PCG_MODE_RUN);
      settle_en(32'h00100040, 32'h1);
      ahb_rd_chk(PCG_CFG_OFS, 32'h1);
      $display("mode test done");
      complete_run();
   end
endmodule
`default_nettype wire
